// ===== hw/iosad_decoder.sv
module iosad_decoder
  import iosad_pkg::*;
(
  input logic i_mclk,
  input logic i_nrst,
  input logic i_req,
  input iosad_op_t i_op,
  input logic [7:0] i_addr,
  input logic [7:0] i_wdata,
  input logic [2:0] i_bit,
  input logic [7:0] i_flag_evt,
  output logic o_ack,
  output logic o_hit,
  output logic o_skip,
  output logic [7:0] o_rdata,
  output logic [7:0] o_flags,
  output logic [7:0] o_gp0,
  output logic [7:0] o_gp1,
  output logic [7:0] o_gp2
);

  iosad_state_t q;
  iosad_state_t d;
  logic [8:0] io_map;
  logic [7:0] io_idx;
  logic io_ok;
  logic ext_ok;
  logic [7:0] cur;
  logic [7:0] ext_idx;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic skip_ref;

  function automatic logic is_data_op(input iosad_op_t op);
    return (op == OP_DATA_SPACE_LOAD_INSTR) || (op == OP_DATA_SPACE_STORE_INSTR);
  endfunction

  function automatic logic is_bit_op(input iosad_op_t op);
    return (op == OP_IO_BIT_SET_INSTR) || (op == OP_IO_BIT_CLEAR_INSTR) ||
           (op == OP_SKIP_IF_IO_BIT_SET_INSTR) || (op == OP_SKIP_IF_IO_BIT_CLEAR_INSTR);
  endfunction

  // Returns {valid, short address} for an access to the short window
  function automatic logic [8:0] map_io(input iosad_op_t op, input logic [7:0] a);
    logic [8:0] r;
    r = '0;
    if (is_data_op(op)) begin
      if ((a >= IO_DATA_OFS) && (a < EXT_FIRST)) begin
        r = {1'b1, 8'(a - IO_DATA_OFS)};
      end
    end else if (is_bit_op(op)) begin
      r = {1'b1, 3'b000, a[4:0]};
    end else begin
      r = {1'b1, 2'b00, a[5:0]};
    end
    return r;
  endfunction

  function automatic logic is_impl(input logic [7:0] idx);
    return (idx == STAT_IO) || (idx == GP0_IO) || (idx == GP1_IO) || (idx == GP2_IO);
  endfunction

  function automatic logic [7:0] rd_io(input logic [7:0] idx, input iosad_state_t s);
    logic [7:0] v;
    v = ZERO_BYTE;
    unique case (1'b1)
      (idx == STAT_IO): v = s.stat;
      (idx == GP0_IO): v = s.gp0;
      (idx == GP1_IO): v = s.gp1;
      (idx == GP2_IO): v = s.gp2;
      default: v = ZERO_BYTE;
    endcase
    return v;
  endfunction

  assign io_map = map_io(i_op, i_addr);
  assign io_ok = io_map[8];
  assign io_idx = io_map[7:0];
  assign ext_ok = is_data_op(i_op) && (i_addr >= EXT_FIRST);
  assign ext_idx = 8'(i_addr - EXT_FIRST);
  assign cur = rd_io(io_idx, q);
  assign skip_ref = cur[i_bit];
  assign mem_we = i_req && ext_ok && (i_op == OP_DATA_SPACE_STORE_INSTR);

  always_comb begin
    d = q;
    d.ack = i_req;
    d.hit = 1'b0;
    d.skip = 1'b0;
    d.mem_sel = 1'b0;
    if (i_req) begin
      d.rdata = ZERO_BYTE;
      if (io_ok) begin
        d.hit = is_impl(io_idx);
        d.rdata = cur;
        unique case (i_op)
          OP_DATA_SPACE_STORE_INSTR, OP_IO_OUT_INSTR: begin
            d.rdata = ZERO_BYTE;
            if (io_idx == STAT_IO) begin
              d.stat = q.stat & ~i_wdata;
            end
            if (io_idx == GP0_IO) begin
              d.gp0 = i_wdata;
            end
            if (io_idx == GP1_IO) begin
              d.gp1 = i_wdata;
            end
            if (io_idx == GP2_IO) begin
              d.gp2 = i_wdata;
            end
          end
          OP_IO_BIT_SET_INSTR: begin
            d.rdata = ZERO_BYTE;
            if (io_idx == STAT_IO) begin
              d.stat[i_bit] = 1'b0;
            end
            if (io_idx == GP0_IO) begin
              d.gp0[i_bit] = 1'b1;
            end
          end
          OP_IO_BIT_CLEAR_INSTR: begin
            d.rdata = ZERO_BYTE;
            if (io_idx == GP0_IO) begin
              d.gp0[i_bit] = 1'b0;
            end
          end
          OP_SKIP_IF_IO_BIT_SET_INSTR: begin
            d.skip = skip_ref;
          end
          OP_SKIP_IF_IO_BIT_CLEAR_INSTR: begin
            d.skip = ~skip_ref;
          end
          OP_DATA_SPACE_LOAD_INSTR, OP_IO_IN_INSTR: begin
            d.rdata = cur;
          end
        endcase
      end else if (ext_ok) begin
        d.hit = 1'b1;
        d.mem_sel = (i_op == OP_DATA_SPACE_LOAD_INSTR);
      end
    end
    // Peripheral events win over a same-cycle clear so none is lost
    d.stat = d.stat | i_flag_evt;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q.stat <= STAT_RST;
      q.gp0 <= GP_RST;
      q.gp1 <= GP_RST;
      q.gp2 <= GP_RST;
      q.rdata <= ZERO_BYTE;
      q.ack <= 1'b0;
      q.skip <= 1'b0;
      q.mem_sel <= 1'b0;
      q.hit <= 1'b0;
    end else begin
      q <= d;
    end
  end

  iosad_ext_mem u_ext_mem (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(mem_we),
    .i_idx(ext_idx),
    .i_wdata(i_wdata),
    .o_rdata(mem_rdata)
  );

  assign o_ack = q.ack;
  assign o_hit = q.hit;
  assign o_skip = q.skip;
  // Both sources are registers; the select only steers between them
  assign o_rdata = q.mem_sel ? mem_rdata : q.rdata;
  assign o_flags = q.stat;
  assign o_gp0 = q.gp0;
  assign o_gp1 = q.gp1;
  assign o_gp2 = q.gp2;

  ext_store_load_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && mem_we) ##1 (i_req && (i_op == OP_DATA_SPACE_LOAD_INSTR) && (i_addr == $past(i_addr)))
    |=> (o_rdata == $past(i_wdata, 2)))
    else $error("extended load did not return stored byte");

  bit_set_gp_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_BIT_SET_INSTR) && (i_addr[4:0] == GP0_IO[4:0]))
    |=> (o_gp0 == ($past(o_gp0) | (8'h01 << $past(i_bit)))))
    else $error("bit set did not set exactly one bit");

  skip_test_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_SKIP_IF_IO_BIT_CLEAR_INSTR))
    |=> (o_skip == !$past(skip_ref)) && (o_flags == ($past(o_flags) | $past(i_flag_evt))))
    else $error("skip result wrong or state disturbed");

  io_in_read_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_IN_INSTR) && (i_addr[5:0] == GP1_IO[5:0]))
    |=> o_ack && o_hit && (o_rdata == $past(o_gp1)))
    else $error("input instruction read wrong register");

  data_offset_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_DATA_SPACE_STORE_INSTR) && (i_addr == 8'(GP2_IO + IO_DATA_OFS)))
    |=> (o_gp2 == $past(i_wdata)) && $stable(o_gp0) && $stable(o_gp1))
    else $error("offset store missed general register");

  short_field_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && !is_data_op(i_op)) |-> !mem_we ##1 !q.mem_sel)
    else $error("short instruction reached extended space");

  ext_only_data_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    mem_we |-> is_data_op(i_op) && (i_addr >= EXT_FIRST) && (i_addr <= EXT_LAST))
    else $error("extended write from wrong instruction");

  flag_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_OUT_INSTR) && (i_addr[5:0] == STAT_IO[5:0]))
    |=> (o_flags == (($past(o_flags) & ~$past(i_wdata)) | $past(i_flag_evt))))
    else $error("flag write-one-to-clear wrong");

  bit_only_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_BIT_SET_INSTR) && (i_addr[4:0] == STAT_IO[4:0]))
    |=> (o_flags == (($past(o_flags) & ~(8'h01 << $past(i_bit))) | $past(i_flag_evt))))
    else $error("bit set on flags touched other bits");

  gp_store_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_OUT_INSTR) && (i_addr[5:0] == GP1_IO[5:0]))
    |=> (o_gp1 == $past(i_wdata)) && $stable(o_gp0))
    else $error("general register store failed");

  gp_bit_clr_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_BIT_CLEAR_INSTR) && (i_addr[4:0] == GP0_IO[4:0]))
    |=> (o_gp0 == ($past(o_gp0) & ~(8'h01 << $past(i_bit)))))
    else $error("bit clear on general register wrong");

  unimpl_zero_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && io_ok && !is_impl(io_idx) && !is_bit_op(i_op))
    |=> !o_hit && (o_rdata == ZERO_BYTE) && $stable(o_gp0) && $stable(o_gp1) && $stable(o_gp2))
    else $error("unimplemented location responded");

  skip_set_gp_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_SKIP_IF_IO_BIT_SET_INSTR) && (i_addr[4:0] == GP0_IO[4:0]))
    |=> o_ack && (o_skip == $past(o_gp0[i_bit])) && $stable(o_gp0))
    else $error("skip on general register wrong");

  ext_load_hit_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && is_data_op(i_op) && (i_addr >= EXT_FIRST))
    |=> o_ack && o_hit)
    else $error("extended access not answered");

  ack_timing_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    1'b1 |=> (o_ack == $past(i_req)))
    else $error("acknowledge not one cycle after request");

  low_data_zero_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && is_data_op(i_op) && (i_addr < IO_DATA_OFS))
    |=> !o_hit && (o_rdata == ZERO_BYTE) && $stable(o_gp0) && $stable(o_gp1) && $stable(o_gp2))
    else $error("working register address reached short window");

  flag_bit_keep_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_BIT_CLEAR_INSTR) && (i_addr[4:0] == STAT_IO[4:0]))
    |=> (o_flags == ($past(o_flags) | $past(i_flag_evt))))
    else $error("bit clear on flags changed a flag");

  io_upper_ign_a: assert property (
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_req && (i_op == OP_IO_OUT_INSTR) && (i_addr[5:0] == GP2_IO[5:0]))
    |=> (o_gp2 == $past(i_wdata)))
    else $error("output instruction missed general register");

endmodule // iosad_decoder

// ===== shared/iosad_pkg.sv
package iosad_pkg;

  localparam int DW = 8;
  localparam int AW = 8;
  localparam int BIT_W = 3;

  // Offset between short input/output addresses and data-space addresses
  localparam logic [7:0] IO_DATA_OFS = 8'h20;
  localparam logic [7:0] BIT_WIN_LAST = 8'h1F;
  localparam logic [7:0] IO_WIN_LAST = 8'h3F;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  localparam int EXT_DEPTH = 160;

  // Implemented input/output register locations (short addresses)
  localparam logic [7:0] STAT_IO = 8'h16;
  localparam logic [7:0] GP0_IO = 8'h1E;
  localparam logic [7:0] GP1_IO = 8'h2A;
  localparam logic [7:0] GP2_IO = 8'h2B;

  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] GP_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_DATA_SPACE_LOAD_INSTR,
    OP_DATA_SPACE_STORE_INSTR,
    OP_IO_IN_INSTR,
    OP_IO_OUT_INSTR,
    OP_IO_BIT_SET_INSTR,
    OP_IO_BIT_CLEAR_INSTR,
    OP_SKIP_IF_IO_BIT_SET_INSTR,
    OP_SKIP_IF_IO_BIT_CLEAR_INSTR
  } iosad_op_t;

  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] gp0;
    logic [7:0] gp1;
    logic [7:0] gp2;
    logic [7:0] rdata;
    logic ack;
    logic skip;
    logic mem_sel;
    logic hit;
  } iosad_state_t;

  typedef struct packed {
    logic [EXT_DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } iosad_mem_state_t;

endpackage

// ===== hw/iosad_ext_mem.sv
module iosad_ext_mem
  import iosad_pkg::*;
(
  input logic i_mclk,
  input logic i_nrst,
  input logic i_we,
  input logic [7:0] i_idx,
  input logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  iosad_mem_state_t q;
  iosad_mem_state_t d;

  // Reset clears the whole array so that the extended window reads defined data
  always_comb begin
    d = q;
    // Indexes past the array read zero instead of unknown
    d.rdata = (i_idx < 8'(EXT_DEPTH)) ? q.mem[i_idx] : ZERO_BYTE;
    if (i_we) begin
      d.mem[i_idx] = i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;

endmodule // iosad_ext_mem

// ===== testbench/iosad_core_model.sv
module iosad_core_model
  import iosad_pkg::*;
(
  input logic i_mclk,
  input logic i_ack,
  input logic i_hit,
  input logic i_skip,
  input logic [7:0] i_rdata,
  output logic o_req,
  output iosad_op_t o_op,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic [2:0] o_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_req = 1'b0;
    o_op = OP_DATA_SPACE_LOAD_INSTR;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_bit = 3'h0;
  end

  // One access; ok stays low if no answer comes
  task automatic access(input iosad_op_t op, input logic [7:0] addr, input logic [7:0] wdata,
                        input logic [2:0] bidx, output logic [7:0] rdata, output logic skip,
                        output logic hit, output logic ok);
    ok = 1'b0;
    @(negedge i_mclk);
    o_req = 1'b1;
    o_op = op;
    o_addr = addr;
    o_wdata = wdata;
    o_bit = bidx;
    @(negedge i_mclk);
    o_req = 1'b0;
    // Released address and write data lines flip so a stale value never looks live
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        rdata = i_rdata;
        skip = i_skip;
        hit = i_hit;
      end else begin
        @(negedge i_mclk);
      end
    end
  endtask

  // Store then load of one address in consecutive cycles; ok needs both answers
  task automatic store_load(input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata,
                            output logic ok);
    @(negedge i_mclk);
    o_req = 1'b1;
    o_op = OP_DATA_SPACE_STORE_INSTR;
    o_addr = addr;
    o_wdata = wdata;
    @(negedge i_mclk);
    ok = (i_ack === 1'b1);
    o_op = OP_DATA_SPACE_LOAD_INSTR;
    o_wdata = ~wdata;
    @(negedge i_mclk);
    ok = ok && (i_ack === 1'b1);
    rdata = i_rdata;
    o_req = 1'b0;
    o_addr = ~addr;
  endtask
endmodule // iosad_core_model

// ===== testbench/iosad_decoder_tb.sv
module iosad_decoder_tb
  import iosad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_flag_evt = 8'h00;
  logic req, ack, hit, skip, ok, sk, ht;
  iosad_op_t op;
  logic [7:0] addr, wdata, rdata, flags, gp0, gp1, gp2, rd;
  logic [2:0] bidx;
  int failures = 0;
  int check_count = 0;

  always #5 i_mclk = ~i_mclk;

  iosad_decoder dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(req), .i_op(op), .i_addr(addr),
    .i_wdata(wdata), .i_bit(bidx), .i_flag_evt(i_flag_evt), .o_ack(ack), .o_hit(hit), .o_skip(skip),
    .o_rdata(rdata), .o_flags(flags), .o_gp0(gp0), .o_gp1(gp1), .o_gp2(gp2));

  iosad_core_model core_u (.i_mclk(i_mclk), .i_ack(ack), .i_hit(hit), .i_skip(skip), .i_rdata(rdata),
    .o_req(req), .o_op(op), .o_addr(addr), .o_wdata(wdata), .o_bit(bidx));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input iosad_op_t o, input logic [7:0] a, input logic [7:0] w, input logic [2:0] b);
    core_u.access(o, a, w, b, rd, sk, ht, ok);
    if (!ok) begin
      failures++;
      conclude();
    end
  endtask

  task automatic t_reset();
    check(flags, STAT_RST);
    check(gp0, GP_RST);
    check(gp1, GP_RST);
    check(gp2, GP_RST);
    $display("test reset done");
  endtask

  task automatic t_gp_paths();
    acc(OP_IO_OUT_INSTR, GP1_IO, 8'hA5, 3'h0);
    acc(OP_DATA_SPACE_LOAD_INSTR, GP1_IO + IO_DATA_OFS, 8'h00, 3'h0);
    check(rd, 8'hA5);
    check({7'h00, ht}, 8'h01);
    acc(OP_DATA_SPACE_STORE_INSTR, GP2_IO + IO_DATA_OFS, 8'h3C, 3'h0);
    acc(OP_IO_IN_INSTR, GP2_IO, 8'h00, 3'h0);
    check(rd, 8'h3C);
    // Upper address bits of an output instruction are ignored
    acc(OP_IO_OUT_INSTR, 8'hEB, 8'h69, 3'h0);
    check(gp2, 8'h69);
    acc(OP_DATA_SPACE_STORE_INSTR, GP0_IO + IO_DATA_OFS, 8'h81, 3'h0);
    check(gp0, 8'h81);
    check(gp1, 8'hA5);
    $display("test gp paths done");
  endtask

  task automatic t_bits();
    acc(OP_IO_BIT_SET_INSTR, GP0_IO, 8'h00, 3'h2);
    acc(OP_IO_BIT_CLEAR_INSTR, GP0_IO, 8'h00, 3'h7);
    check(gp0, 8'h05);
    acc(OP_SKIP_IF_IO_BIT_SET_INSTR, GP0_IO, 8'h00, 3'h0);
    check({7'h00, sk}, 8'h01);
    acc(OP_SKIP_IF_IO_BIT_SET_INSTR, GP0_IO, 8'h00, 3'h1);
    check({7'h00, sk}, 8'h00);
    acc(OP_SKIP_IF_IO_BIT_CLEAR_INSTR, GP0_IO, 8'h00, 3'h1);
    check({7'h00, sk}, 8'h01);
    $display("test bit ops done");
  endtask

  task automatic t_flags();
    @(negedge i_mclk);
    i_flag_evt = 8'h0F;
    @(negedge i_mclk);
    i_flag_evt = 8'h00;
    check(flags, 8'h0F);
    acc(OP_DATA_SPACE_STORE_INSTR, STAT_IO + IO_DATA_OFS, 8'h01, 3'h0);
    check(flags, 8'h0E);
    acc(OP_IO_OUT_INSTR, STAT_IO, 8'h00, 3'h0);
    check(flags, 8'h0E);
    acc(OP_IO_BIT_CLEAR_INSTR, STAT_IO, 8'h00, 3'h3);
    check(flags, 8'h0E);
    acc(OP_IO_BIT_SET_INSTR, STAT_IO, 8'h00, 3'h2);
    check(flags, 8'h0A);
    $display("test flags done");
  endtask

  task automatic t_ext();
    acc(OP_DATA_SPACE_STORE_INSTR, EXT_FIRST, 8'h5A, 3'h0);
    acc(OP_DATA_SPACE_STORE_INSTR, EXT_LAST, 8'hC3, 3'h0);
    acc(OP_DATA_SPACE_LOAD_INSTR, EXT_FIRST, 8'h00, 3'h0);
    check(rd, 8'h5A);
    acc(OP_DATA_SPACE_LOAD_INSTR, EXT_LAST, 8'h00, 3'h0);
    check(rd, 8'hC3);
    acc(OP_IO_IN_INSTR, EXT_FIRST, 8'h00, 3'h0);
    check({ht, rd[6:0]}, 8'h00);
    $display("test extended done");
  endtask

  task automatic t_unmapped();
    // Only reads here: software never writes reserved places
    // reads only
    acc(OP_DATA_SPACE_LOAD_INSTR, 8'h10, 8'h00, 3'h0);
    check({ht, rd[6:0]}, 8'h00);
    acc(OP_IO_IN_INSTR, 8'h05, 8'h00, 3'h0);
    check(rd, ZERO_BYTE);
    $display("test unmapped done");
  endtask

  task automatic t_back_to_back();
    core_u.store_load(8'h80, 8'h96, rd, ok);
    check({7'h00, ok}, 8'h01);
    check(rd, 8'h96);
    $display("test back to back done");
  endtask

  initial begin
    repeat (6) @(negedge i_mclk);
    i_nrst = 1'b1;
    t_reset();
    t_gp_paths();
    t_bits();
    t_flags();
    t_ext();
    t_unmapped();
    t_back_to_back();
    conclude();
  end
endmodule // iosad_decoder_tb
